// File: src/fer_regs.svh
// Constants of the fault and event recorder.
`ifndef FER_REGS_SVH
`define FER_REGS_SVH
`define FER_CLK_HZ        100000000
`define FER_SAMPLE_HZ     1200
`define FER_SAMPLE_CYC    (`FER_CLK_HZ / `FER_SAMPLE_HZ)
`define FER_SEC_CYC       `FER_CLK_HZ
`define FER_EVT_DEPTH     30
`define FER_LEN_MIN_S     1
`define FER_LEN_MAX_S     5
`define FER_REC_MAX_AT_1S 5
`define FER_ANA_CH        7
`define FER_BIN_CH        32
`endif

// File: src/fer_pkg.sv
// Types of the fault and event recorder.
package fer_pkg;
   typedef enum logic [1:0] {
      FER_IDLE = 2'b00,
      FER_PRE  = 2'b01,
      FER_POST = 2'b10
   } fer_rec_state_t;
   typedef enum logic [1:0] {
      FER_SYNC_NONE  = 2'b00,
      FER_SYNC_BUS   = 2'b01,
      FER_SYNC_CODE  = 2'b10,
      FER_SYNC_PANEL = 2'b11
   } fer_sync_src_t;
endpackage

// File: src/fer_recorder.sv
// Fault and event recorder: clock, event store and ring of fault records.
`timescale 1ns/10ps
`include "fer_regs.svh"
module fer_recorder #(
   parameter int SEC_CYC    = `FER_SEC_CYC,
   parameter int SAMPLE_CYC = `FER_SAMPLE_CYC,
   parameter int SMP_W      = 16,
   parameter int RMS_W      = 16,
   parameter int ID_W       = 8,
   parameter int REC_WORDS  = 6000
) (
   input  wire logic                         clk,
   input  wire logic                         arst_n,
   // Clock setting: bus sync, decoded time code and panel write.
   input  wire logic                         bus_time_wr,
   input  wire logic                         code_time_wr,
   input  wire logic                         panel_time_wr,
   input  wire logic [16:0]                  time_in,
   input  wire logic [15:0]                  date_in,
   input  wire logic                         code_pps_pin,
   output logic      [16:0]                  time_of_day,
   output logic      [15:0]                  date_out,
   output logic      [1:0]                   last_sync_src,
   // Event input.
   input  wire logic                         evt_valid,
   input  wire logic [ID_W-1:0]              evt_id,
   input  wire logic [RMS_W-1:0]             evt_rms,
   input  wire logic [4:0]                   evt_rd_idx,
   output logic      [ID_W+RMS_W+32:0]       evt_rd_data,
   output logic      [4:0]                   evt_count,
   // Setup of the recorder.
   input  wire logic                         cfg_load,
   input  wire logic [2:0]                   cfg_len_s,
   input  wire logic [2:0]                   cfg_pre_s,
   input  wire logic [`FER_ANA_CH-1:0]       cfg_ana_en,
   input  wire logic [`FER_BIN_CH-1:0]       cfg_bin_en,
   // Samples and trigger.
   input  wire logic [`FER_ANA_CH*SMP_W-1:0] ana_in,
   input  wire logic [`FER_BIN_CH-1:0]       bin_in,
   input  wire logic                         trigger,
   output logic                              recording,
   output logic      [2:0]                   rec_stored,
   // Readout stream of the finished record chosen by rd_rec, through a two-entry buffer.
   input  wire logic                         rd_start,
   input  wire logic [2:0]                   rd_rec,
   output logic                              rd_valid,
   input  wire logic                         rd_ready,
   output logic      [`FER_ANA_CH*SMP_W+`FER_BIN_CH-1:0] rd_data
);
   localparam int WORD_W = `FER_ANA_CH * SMP_W + `FER_BIN_CH;
   localparam int SPS    = `FER_SAMPLE_HZ;
   localparam int ADR_W  = $clog2(REC_WORDS);
   localparam int EW     = ID_W + RMS_W + 33;

   // ======================================================================
   // Real-time clock
   // ======================================================================
   logic [31:0]          sec_cnt_ff, nxt_sec_cnt;
   logic [16:0]          tod_ff, nxt_tod;
   logic [15:0]          date_ff, nxt_date;
   logic [1:0]           src_ff, nxt_src;
   logic                 pps_s1_ff, pps_s2_ff, pps_s3_ff;

   always_comb begin
      nxt_sec_cnt = sec_cnt_ff + 32'h1;
      nxt_tod     = tod_ff;
      nxt_date    = date_ff;
      nxt_src     = src_ff;
      if (sec_cnt_ff == 32'(SEC_CYC - 1)) begin
         nxt_sec_cnt = 32'h0;
         nxt_tod     = (tod_ff == 17'h1517f) ? 17'h0 : tod_ff + 17'h1;
         if (tod_ff == 17'h1517f) nxt_date = date_ff + 16'h1;
      end
      // The time-code second mark realigns the second boundary only.
      if (pps_s2_ff && !pps_s3_ff) nxt_sec_cnt = 32'h0;
      if (panel_time_wr || code_time_wr || bus_time_wr) begin
         nxt_tod     = time_in;
         nxt_date    = date_in;
         nxt_sec_cnt = 32'h0;
         nxt_src     = panel_time_wr ? fer_pkg::FER_SYNC_PANEL
                     : code_time_wr  ? fer_pkg::FER_SYNC_CODE : fer_pkg::FER_SYNC_BUS;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sec_cnt_ff <= 32'h0;
         tod_ff     <= 17'h0;
         date_ff    <= 16'h0;
         src_ff     <= 2'h0;
         pps_s1_ff  <= 1'b0;
         pps_s2_ff  <= 1'b0;
         pps_s3_ff  <= 1'b0;
      end else begin
         sec_cnt_ff <= nxt_sec_cnt;
         tod_ff     <= nxt_tod;
         date_ff    <= nxt_date;
         src_ff     <= nxt_src;
         pps_s1_ff  <= code_pps_pin;
         pps_s2_ff  <= pps_s1_ff;
         pps_s3_ff  <= pps_s2_ff;
      end
   end

   assign time_of_day   = tod_ff;
   assign date_out      = date_ff;
   assign last_sync_src = src_ff;

   // ======================================================================
   // Event store
   // ======================================================================
   logic [EW-1:0]        evt_mem [`FER_EVT_DEPTH];
   logic [4:0]           evt_wp_ff, nxt_evt_wp;
   logic [4:0]           evt_cnt_ff, nxt_evt_cnt;
   logic [EW-1:0]        evt_rd_ff, nxt_evt_rd;
   logic [4:0]           rd_slot;

   always_comb begin
      nxt_evt_wp  = evt_wp_ff;
      nxt_evt_cnt = evt_cnt_ff;
      if (evt_valid) begin
         nxt_evt_wp = (evt_wp_ff == 5'(`FER_EVT_DEPTH - 1)) ? 5'h0 : evt_wp_ff + 5'h1;
         if (evt_cnt_ff != 5'(`FER_EVT_DEPTH)) nxt_evt_cnt = evt_cnt_ff + 5'h1;
      end
      // Index 0 is the newest entry.
      rd_slot = (evt_wp_ff > evt_rd_idx) ? evt_wp_ff - evt_rd_idx - 5'h1
              : 5'(`FER_EVT_DEPTH) + evt_wp_ff - evt_rd_idx - 5'h1;
      nxt_evt_rd = (evt_rd_idx < 5'(`FER_EVT_DEPTH)) ? evt_mem[rd_slot] : '0;
   end

   always_ff @(posedge clk) begin
      if (evt_valid) begin
         evt_mem[evt_wp_ff] <= {evt_id, tod_ff, date_ff, evt_rms};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         evt_wp_ff  <= 5'h0;
         evt_cnt_ff <= 5'h0;
         evt_rd_ff  <= '0;
      end else begin
         evt_wp_ff  <= nxt_evt_wp;
         evt_cnt_ff <= nxt_evt_cnt;
         evt_rd_ff  <= nxt_evt_rd;
      end
   end

   // The count holds at thirty; from then on each new event overwrites the oldest.
   assign evt_count   = evt_cnt_ff;
   assign evt_rd_data = evt_rd_ff;

   // ======================================================================
   // Fault recorder
   // ======================================================================
   logic [WORD_W-1:0]    rec_mem [REC_WORDS];
   fer_pkg::fer_rec_state_t st_ff, nxt_st;
   logic [31:0]          smp_div_ff, nxt_smp_div;
   logic [ADR_W-1:0]     wp_ff, nxt_wp;
   logic [31:0]          fill_ff, nxt_fill;
   logic [31:0]          post_ff, nxt_post;
   logic [2:0]           len_ff, nxt_len, pre_ff, nxt_pre;
   logic [`FER_ANA_CH-1:0] ana_en_ff, nxt_ana_en;
   logic [`FER_BIN_CH-1:0] bin_en_ff, nxt_bin_en;
   logic [2:0]           nrec_ff, nxt_nrec, head_ff, nxt_head;
   logic [ADR_W-1:0]     rec_base [5];
   logic                 smp_tick, wr_en, rec_ff;
   logic [WORD_W-1:0]    smp_word;
   logic [31:0]          rec_len_smp, pre_smp, slots;

   // Ring slot count: five one-second records, fewer as length grows.
   assign rec_len_smp = 32'(len_ff) * 32'(SPS);
   assign pre_smp     = 32'(pre_ff) * 32'(SPS);
   assign slots       = 32'(`FER_REC_MAX_AT_1S) / 32'(len_ff);
   assign smp_tick    = (smp_div_ff == 32'(SAMPLE_CYC - 1));

   genvar g;
   generate
      for (g = 0; g < `FER_ANA_CH; g++) begin : g_ana
         assign smp_word[g*SMP_W +: SMP_W] = ana_en_ff[g] ? ana_in[g*SMP_W +: SMP_W] : '0;
      end
   endgenerate
   assign smp_word[WORD_W-1 -: `FER_BIN_CH] = bin_in & bin_en_ff;

   always_comb begin
      nxt_st      = st_ff;
      nxt_smp_div = smp_tick ? 32'h0 : smp_div_ff + 32'h1;
      nxt_wp      = wp_ff;
      nxt_fill    = fill_ff;
      nxt_post    = post_ff;
      nxt_len     = len_ff;
      nxt_pre     = pre_ff;
      nxt_ana_en  = ana_en_ff;
      nxt_bin_en  = bin_en_ff;
      nxt_nrec    = nrec_ff;
      nxt_head    = head_ff;
      wr_en       = 1'b0;
      case (st_ff)
         fer_pkg::FER_IDLE: begin
            if (cfg_load && cfg_len_s >= 3'(`FER_LEN_MIN_S) && cfg_len_s <= 3'(`FER_LEN_MAX_S)
                && cfg_pre_s < cfg_len_s) begin
               nxt_len    = cfg_len_s;
               nxt_pre    = cfg_pre_s;
               nxt_ana_en = cfg_ana_en;
               nxt_bin_en = cfg_bin_en;
               nxt_st     = fer_pkg::FER_PRE;
               nxt_wp     = rec_base[head_ff];
               nxt_fill   = 32'h0;
               nxt_nrec   = 3'h0;
            end
         end
         fer_pkg::FER_PRE: begin
            if (smp_tick) begin
               wr_en = 1'b1;
               nxt_wp = (32'(wp_ff) - 32'(rec_base[head_ff]) == rec_len_smp - 32'h1)
                        ? rec_base[head_ff] : wp_ff + ADR_W'(1);
               if (fill_ff < pre_smp) nxt_fill = fill_ff + 32'h1;
            end
            if (trigger && fill_ff >= pre_smp) begin
               nxt_st   = fer_pkg::FER_POST;
               nxt_post = rec_len_smp - pre_smp;
            end
         end
         fer_pkg::FER_POST: begin
            if (smp_tick) begin
               wr_en = 1'b1;
               nxt_wp = (32'(wp_ff) - 32'(rec_base[head_ff]) == rec_len_smp - 32'h1)
                        ? rec_base[head_ff] : wp_ff + ADR_W'(1);
               nxt_post = post_ff - 32'h1;
               if (post_ff == 32'h1) begin
                  nxt_head = (32'(head_ff) == slots - 32'h1) ? 3'h0 : head_ff + 3'h1;
                  if (32'(nrec_ff) < slots) nxt_nrec = nrec_ff + 3'h1;
                  nxt_st   = fer_pkg::FER_PRE;
                  nxt_fill = 32'h0;
                  nxt_wp   = rec_base[nxt_head];
               end
            end
         end
         default: nxt_st = fer_pkg::FER_IDLE;
      endcase
   end

   generate
      for (g = 0; g < 5; g++) begin : g_base
         assign rec_base[g] = ADR_W'(32'(g) * 32'(len_ff) * 32'(SPS));
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (wr_en) rec_mem[wp_ff] <= smp_word;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_ff      <= fer_pkg::FER_IDLE;
         smp_div_ff <= 32'h0;
         wp_ff      <= '0;
         fill_ff    <= 32'h0;
         post_ff    <= 32'h0;
         len_ff     <= 3'h1;
         pre_ff     <= 3'h0;
         ana_en_ff  <= '0;
         bin_en_ff  <= '0;
         nrec_ff    <= 3'h0;
         head_ff    <= 3'h0;
         rec_ff     <= 1'b0;
      end else begin
         st_ff      <= nxt_st;
         smp_div_ff <= nxt_smp_div;
         wp_ff      <= nxt_wp;
         fill_ff    <= nxt_fill;
         post_ff    <= nxt_post;
         len_ff     <= nxt_len;
         pre_ff     <= nxt_pre;
         ana_en_ff  <= nxt_ana_en;
         bin_en_ff  <= nxt_bin_en;
         nrec_ff    <= nxt_nrec;
         head_ff    <= nxt_head;
         rec_ff     <= (nxt_st == fer_pkg::FER_POST);
      end
   end

   assign recording  = rec_ff;
   assign rec_stored = nrec_ff;

   // ======================================================================
   // Readout with two-entry buffer
   // ======================================================================
   // Words read in ring order from the slot start; pre-fault order is left to software.
   logic [31:0]          rd_left_ff, nxt_rd_left;
   logic [ADR_W-1:0]     ra_ff, nxt_ra;
   logic [WORD_W-1:0]    buf_ff [2], nxt_buf [2];
   logic [1:0]           bcnt_ff, nxt_bcnt;
   logic                 push, pop, vld_ff;

   assign pop  = (bcnt_ff != 2'h0) && rd_ready;
   assign push = (rd_left_ff != 32'h0) && (bcnt_ff != 2'h2 || pop);

   always_comb begin
      nxt_rd_left = rd_left_ff;
      nxt_ra      = ra_ff;
      nxt_buf     = buf_ff;
      nxt_bcnt    = bcnt_ff;
      if (rd_start && rd_left_ff == 32'h0 && rd_rec < nrec_ff) begin
         nxt_rd_left = rec_len_smp;
         nxt_ra      = rec_base[rd_rec];
      end
      if (pop) begin
         nxt_buf[0] = buf_ff[1];
      end
      if (push) begin
         nxt_buf[(pop ? bcnt_ff - 2'h1 : bcnt_ff) == 2'h0 ? 0 : 1] = rec_mem[ra_ff];
         nxt_ra      = ra_ff + ADR_W'(1);
         nxt_rd_left = rd_left_ff - 32'h1;
      end
      nxt_bcnt = bcnt_ff + (push ? 2'h1 : 2'h0) - (pop ? 2'h1 : 2'h0);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_left_ff <= 32'h0;
         ra_ff      <= '0;
         buf_ff     <= '{default: '0};
         bcnt_ff    <= 2'h0;
         vld_ff     <= 1'b0;
      end else begin
         rd_left_ff <= nxt_rd_left;
         ra_ff      <= nxt_ra;
         buf_ff     <= nxt_buf;
         bcnt_ff    <= nxt_bcnt;
         vld_ff     <= (nxt_bcnt != 2'h0);
      end
   end

   assign rd_valid = vld_ff;
   assign rd_data  = buf_ff[0];
endmodule

// File: bench/fer_recorder_props.sv
// Concurrent checks on the ports of the fault and event recorder.
`timescale 1ns/10ps
`include "fer_regs.svh"
module fer_recorder_props #(
   parameter int SMP_W = 16
) (
   input wire logic                                     clk,
   input wire logic                                     arst_n,
   input wire logic                                     bus_time_wr,
   input wire logic                                     code_time_wr,
   input wire logic                                     panel_time_wr,
   input wire logic [16:0]                              time_in,
   input wire logic [15:0]                              date_in,
   input wire logic [16:0]                              time_of_day,
   input wire logic [15:0]                              date_out,
   input wire logic [1:0]                               last_sync_src,
   input wire logic                                     evt_valid,
   input wire logic [4:0]                               evt_count,
   input wire logic [2:0]                               rec_stored,
   input wire logic                                     rd_start,
   input wire logic [2:0]                               rd_rec,
   input wire logic                                     rd_valid,
   input wire logic                                     rd_ready,
   input wire logic [`FER_ANA_CH*SMP_W+`FER_BIN_CH-1:0] rd_data
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_evt_depth_cap: assert property (evt_count <= 5'h1e)
      else $error("event count above thirty");
   a_evt_count_step: assert property (evt_valid && evt_count < 5'h1e |=>
      evt_count == $past(evt_count) + 5'h01) else $error("event count did not step");
   a_evt_full_hold: assert property (evt_valid && evt_count == 5'h1e |=>
      evt_count == 5'h1e) else $error("full event store changed count");
   a_panel_set_time: assert property (panel_time_wr |=> last_sync_src == 2'h3 &&
      time_of_day == $past(time_in) && date_out == $past(date_in))
      else $error("panel write not applied");
   a_code_set_src: assert property (code_time_wr && !panel_time_wr |=>
      last_sync_src == 2'h2) else $error("time code source not shown");
   a_bus_set_src: assert property (bus_time_wr && !code_time_wr && !panel_time_wr |=>
      last_sync_src == 2'h1) else $error("bus source not shown");
   a_tod_in_range: assert property (time_of_day < 17'h15180)
      else $error("time of day out of range");
   a_ring_max_five: assert property (rec_stored <= 3'h5)
      else $error("more than five records held");
   a_rd_word_hold: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("stalled word lost");
   a_rd_first_word: assert property (rd_start && !rd_valid && rd_rec < rec_stored |->
      ##2 rd_valid) else $error("stream did not start");
endmodule
bind fer_recorder fer_recorder_props #(.SMP_W(SMP_W)) i_props (.*);

// File: bench/fer_partner.sv
// Front end sample source and readout sink facing the recorder.
`timescale 1ns/10ps
`include "fer_regs.svh"
module fer_partner (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              hold,
   input  wire logic              stall,
   output logic [`FER_ANA_CH*16-1:0] ana_in,
   output logic [`FER_BIN_CH-1:0] bin_in,
   output logic                   rd_ready
);
   logic [15:0] cnt_ff;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff <= 16'h0000;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end
   // Samples move every cycle so a missed sampling instant shows up in the data.
   assign ana_in = {`FER_ANA_CH{cnt_ff}};
   assign bin_in = {cnt_ff, ~cnt_ff};
   // A slow sink takes one word in four; hold stops it completely.
   assign rd_ready = !hold && (!stall || cnt_ff[1:0] == 2'h0);
endmodule

// File: bench/fer_recorder_test.sv
// Self-checking testbench of the fault and event recorder.
`timescale 1ns/10ps
module fer_recorder_test;
   logic clk = 1'b0, arst_n = 1'b0, hold = 1'b0, stall = 1'b0;
   logic bus_wr = 1'b0, code_wr = 1'b0, panel_wr = 1'b0, pps = 1'b0;
   logic [16:0] time_in = 17'h00000;
   logic [15:0] date_in = 16'h0000;
   logic evt_valid = 1'b0, cfg_load = 1'b0, trigger = 1'b0, rd_start = 1'b0, rd_ready;
   logic [7:0] evt_id = 8'h00;
   logic [15:0] evt_rms = 16'h0000;
   logic [4:0] evt_rd_idx = 5'h00, evt_count;
   logic [2:0] len_s = 3'h1, rd_rec = 3'h0, rec_stored;
   logic [16:0] tod;
   logic [15:0] date_out;
   logic [1:0] src;
   logic [56:0] evt_rd_data;
   logic [6:0] ana_en = 7'h7f;
   logic [31:0] bin_en = 32'hffffffff, bin_in;
   logic [111:0] ana_in;
   logic [143:0] rd_data;
   logic recording, rd_valid;
   int mismatches = 0, compares = 0, words = 0;
   always #5 clk = ~clk;
   // Each taken word must show the partner's packing: upper binary half copies analog channel 0, lower half its inverse.
   always @(posedge clk) begin
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
         words <= words + 1;
         check(rd_data[143:112], {rd_data[15:0], ~rd_data[15:0]}, "word packing");
         check(rd_data[111:96], rd_data[15:0], "last channel");
      end
   end
   fer_partner i_partner (.clk(clk), .arst_n(arst_n), .hold(hold), .stall(stall),
      .ana_in(ana_in), .bin_in(bin_in), .rd_ready(rd_ready));
   fer_recorder #(.SEC_CYC(100), .SAMPLE_CYC(10)) i_dut (.clk(clk), .arst_n(arst_n),
      .bus_time_wr(bus_wr), .code_time_wr(code_wr), .panel_time_wr(panel_wr),
      .time_in(time_in), .date_in(date_in), .code_pps_pin(pps), .time_of_day(tod),
      .date_out(date_out), .last_sync_src(src), .evt_valid(evt_valid), .evt_id(evt_id),
      .evt_rms(evt_rms), .evt_rd_idx(evt_rd_idx), .evt_rd_data(evt_rd_data),
      .evt_count(evt_count), .cfg_load(cfg_load), .cfg_len_s(len_s), .cfg_pre_s(3'h0),
      .cfg_ana_en(ana_en), .cfg_bin_en(bin_en), .ana_in(ana_in), .bin_in(bin_in),
      .trigger(trigger), .recording(recording), .rec_stored(rec_stored),
      .rd_start(rd_start), .rd_rec(rd_rec), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wait_rec(input logic level);
      int i;
      for (i = 0; i < 20000 && recording !== level; i++) @(posedge clk);
      if (recording !== level) begin
         check(recording, level, "recording wait ran out");
         end_of_test;
      end
   endtask
   task automatic t_clock;
      int s;
      for (s = 0; s < 4; s++) begin
         @(posedge clk);
         time_in <= 17'd1000 + 17'(s);
         date_in <= 16'd200 + 16'(s);
         bus_wr <= (s == 0 || s == 3);
         code_wr <= (s == 1 || s == 3);
         panel_wr <= (s >= 2);
         @(posedge clk);
         {bus_wr, code_wr, panel_wr} <= 3'h0;
         #1;
         check(src, (s == 3) ? 2'h3 : 2'(s + 1), "sync source");
         check(tod, 17'd1000 + 17'(s), "time set");
         check(date_out, 16'd200 + 16'(s), "date set");
      end
   endtask
   task automatic t_pps;
      @(posedge clk) {panel_wr, time_in, date_in} <= {1'b1, 17'd100, 16'd9};
      @(posedge clk) panel_wr <= 1'b0;
      repeat (50) @(posedge clk);
      pps <= 1'b1;
      // The mark lands 53 cycles after the write, so the next second ends at cycle 153.
      repeat (70) @(posedge clk);
      #1;
      check(tod, 17'd100, "second mark realigns");
      repeat (40) @(posedge clk);
      pps <= 1'b0;
      #1;
      check(tod, 17'd101, "second after mark");
   endtask
   task automatic read_evt(input logic [4:0] idx, input logic [7:0] id, input logic [15:0] rms);
      @(posedge clk) evt_rd_idx <= idx;
      repeat (2) @(posedge clk);
      #1;
      check(evt_rd_data[56:49], id, "event identity");
      check(evt_rd_data[48:32], 17'd5000, "event time");
      check(evt_rd_data[31:16], 16'd77, "event date");
      check(evt_rd_data[15:0], rms, "event current");
   endtask
   task automatic t_events;
      int i;
      @(posedge clk) {panel_wr, time_in, date_in} <= {1'b1, 17'd5000, 16'd77};
      @(posedge clk) panel_wr <= 1'b0;
      for (i = 0; i < 31; i++) begin
         evt_valid <= 1'b1;
         evt_id <= 8'(i + 1);
         evt_rms <= 16'h0100 + 16'(i);
         @(posedge clk);
      end
      evt_valid <= 1'b0;
      repeat (2) @(posedge clk);
      check(evt_count, 5'h1e, "event count");
      read_evt(5'h00, 8'h1f, 16'h011e);
      read_evt(5'h1d, 8'h02, 16'h0101);
   endtask
   task automatic run_record(input bit refuse_cfg);
      @(posedge clk) trigger <= 1'b1;
      wait_rec(1'b1);
      trigger <= 1'b0;
      // A setup load in mid-record must be ignored, so the length stays one second.
      if (refuse_cfg) begin
         len_s <= 3'h5;
         cfg_load <= 1'b1;
         @(posedge clk) cfg_load <= 1'b0;
      end
      wait_rec(1'b0);
      len_s <= 3'h1;
   endtask
   task automatic t_read(input logic [2:0] rec);
      int i;
      @(posedge clk) {rd_start, rd_rec, hold, stall} <= {1'b1, rec, 2'b11};
      words <= 0;
      @(posedge clk) rd_start <= 1'b0;
      repeat (30) @(posedge clk);
      hold <= 1'b0;
      for (i = 0; i < 8000 && words < 1200; i++) @(posedge clk);
      if (words < 1200) begin
         check(words, 1200, "stream wait ran out");
         end_of_test();
      end
      repeat (20) @(posedge clk);
      #1;
      check(words, 1200, "words in one second record");
      check(rd_valid, 1'b0, "stream ended");
   endtask
   initial begin
      int r;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk) #1;
      check({evt_count, rec_stored, recording, src}, 11'h000, "reset outputs");
      t_clock();
      t_pps();
      t_events();
      @(posedge clk) cfg_load <= 1'b1;
      @(posedge clk) cfg_load <= 1'b0;
      run_record(1'b1);
      check(rec_stored, 3'h1, "first record stored");
      t_read(3'h0);
      for (r = 0; r < 5; r++) run_record(1'b0);
      check(rec_stored, 3'h5, "ring holds five");
      t_read(3'h4);
      end_of_test();
   end
endmodule
